// ### logic/nvm_ctl_pkg.sv
// package of constants for the nonvolatile program/erase control block
// assumes a single 100 MHz bus clock domain
package nvm_ctl_pkg;
    // clock and widths
    localparam int          MCLK_MHZ        = 100;
    localparam int          PRESCALE_W      = 10;
    localparam int          ROW_BYTES       = 64;
    localparam int          ROW_IDX_W       = 6;
    localparam int          DATA_W          = 8;
    // program control register field positions
    localparam int          PCTL_PULSE_BIT  = 0;
    localparam int          PCTL_LATCH_BIT  = 1;
    localparam int          PCTL_ERASE_BIT  = 2;
    localparam int          PCTL_AUTO_BIT   = 5;
    localparam int          PCTL_W          = 8;
    localparam logic [7:0]  PCTL_RESET      = 8'h00;
    // prescaler split: high register holds bits 9:8
    localparam int          DIVH_W          = 2;
    localparam int          DIVL_W          = 8;
    // fixed flash times in microseconds and in mclk cycles
    localparam int          FLASH_PROG_US   = 20;
    localparam int          FLASH_ERASE_US  = 100;
    localparam int          FLASH_PROG_CYC  = FLASH_PROG_US * MCLK_MHZ;
    localparam int          FLASH_ERASE_CYC = FLASH_ERASE_US * MCLK_MHZ;
    // byte array times in divided ticks
    localparam int          BYTE_PROG_TICKS = 10;
    localparam int          BYTE_ERASE_TICKS= 10;
    localparam int          AUTO_PROG_TICKS = 6;
    localparam int          AUTO_ERASE_TICKS= 6;
    localparam int          SEL_WRITES_MAX  = 8;
    localparam int          TICK_W          = 16;
endpackage

// ### logic/tick_divider.sv
// prescaler that turns oscillator edges into divided ticks
// assumes the oscillator input is already synchronous to mclk
`timescale 1ns/1ns
module tick_divider #(
    parameter int W = 10
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         oscEdge,
    input  wire logic [W-1:0] divRatio,
    output logic              tick
);
    logic [W-1:0] cnt_r;

    // --------------------------------------------------------------
    // divide counter
    // --------------------------------------------------------------
    // count oscillator edges, tick every divRatio+1 of them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (oscEdge) begin
                if (cnt_r >= divRatio) begin
                    cnt_r <= '0;
                    tick  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule // tick_divider

// ### logic/nvm_program_erase_control.sv
// flash row program, flash bulk erase and byte array program/erase timing
// assumes all inputs synchronous to mclk; shadow word stable at reset
//
// Notes on behaviour
// - flash programs one whole 64-byte row per operation
// - flash erase is bulk only, whole array
// - flash program and erase durations are fixed by hardware
// - byte array timebase is clocked from the external oscillator
// - 10-bit prescale split over high and low divider registers
// - divider registers reload from shadow word at every reset
// - auto-timing enable sits at bit 5 of program control
// - in auto mode hardware clears the program pulse bit when done
// - up to eight writes to one byte, then erase, count one cycle
// - stop exit needs no alignment with the interrupt clock
`timescale 1ns/1ns
module nvm_program_erase_control
    import nvm_ctl_pkg::*;
#(
    parameter int FLASH_PROG_CYCLES  = FLASH_PROG_CYC,
    parameter int FLASH_ERASE_CYCLES = FLASH_ERASE_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  external_oscillator_clock,
    input  wire logic [PRESCALE_W-1:0] shadowDivider,
    input  wire logic                  dividerWrHigh,
    input  wire logic                  dividerWrLow,
    input  wire logic [DATA_W-1:0]     dividerWrData,
    input  wire logic                  progCtlWr,
    input  wire logic [PCTL_W-1:0]     progCtlWrData,
    input  wire logic                  byteLatchWr,
    input  wire logic [DATA_W-1:0]     byteLatchData,
    input  wire logic                  flashRowWr,
    input  wire logic [ROW_IDX_W-1:0]  flashRowIdx,
    input  wire logic [DATA_W-1:0]     flashRowData,
    input  wire logic                  flashProgStart,
    input  wire logic                  flashEraseStart,
    input  wire logic                  stopReq,
    input  wire logic                  wakeReq,
    output logic [DIVH_W-1:0]          timebase_divider_high,
    output logic [DIVL_W-1:0]          timebase_divider_low,
    output logic [PCTL_W-1:0]          byte_memory_program_control,
    output logic                       flashBusy,
    output logic                       flashProgPulse,
    output logic                       flashErasePulse,
    output logic [ROW_BYTES*DATA_W-1:0] flashRowOut,
    output logic                       bytePulse,
    output logic [3:0]                 selectiveWrites,
    output logic                       cycleDone,
    output logic                       stopped
);
    typedef enum logic [2:0] {
        FL_IDLE  = 3'b001,
        FL_PROG  = 3'b010,
        FL_ERASE = 3'b100
    } flash_e;

    flash_e       flState_r;
    logic [TICK_W-1:0] flCnt_r;
    logic [TICK_W-1:0] byteTicks_r;
    logic [ROW_BYTES*DATA_W-1:0] rowBuf_r;
    logic         oscPrev_r;
    logic         oscEdge;
    logic         divTick;
    logic         pulseOn;
    logic         autoOn;
    logic         eraseSel;
    logic         doneNow;
    logic [TICK_W-1:0] needTicks;

    assign pulseOn  = byte_memory_program_control[PCTL_PULSE_BIT];
    assign autoOn   = byte_memory_program_control[PCTL_AUTO_BIT];
    assign eraseSel = byte_memory_program_control[PCTL_ERASE_BIT];

    // --------------------------------------------------------------
    // oscillator edge and divided timebase
    // --------------------------------------------------------------
    // edge taken from the oscillator, not the bus clock rate
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oscPrev_r <= 1'b0;
        end else begin
            oscPrev_r <= external_oscillator_clock;
        end
    end
    assign oscEdge = external_oscillator_clock & ~oscPrev_r & ~stopped;

    tick_divider #(.W(PRESCALE_W)) u_div (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .oscEdge  (oscEdge),
        .divRatio ({timebase_divider_high, timebase_divider_low}),
        .tick     (divTick)
    );

    // --------------------------------------------------------------
    // divider registers
    // --------------------------------------------------------------
    // volatile copy restored from the shadow word on each reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timebase_divider_high <=
                shadowDivider[PRESCALE_W-1:DIVL_W];
            timebase_divider_low  <= shadowDivider[DIVL_W-1:0];
        end else begin
            if (dividerWrHigh)
                timebase_divider_high <= dividerWrData[DIVH_W-1:0];
            if (dividerWrLow)
                timebase_divider_low  <= dividerWrData;
        end
    end

    // --------------------------------------------------------------
    // byte array program control and timing
    // --------------------------------------------------------------
    always_comb begin
        if (autoOn)
            needTicks = eraseSel ? TICK_W'(AUTO_ERASE_TICKS)
                                 : TICK_W'(AUTO_PROG_TICKS);
        else
            needTicks = eraseSel ? TICK_W'(BYTE_ERASE_TICKS)
                                 : TICK_W'(BYTE_PROG_TICKS);
    end
    // equality, not >=: manual mode keeps counting past completion, so a
    // threshold test would report completion again on every later tick
    assign doneNow = pulseOn && divTick && (byteTicks_r == needTicks - 1'b1);

    // hardware clear of the pulse bit only in auto mode; a software
    // write in the same cycle loses, so completion is never missed
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            byte_memory_program_control <= PCTL_RESET;
        end else if (autoOn && doneNow) begin
            byte_memory_program_control[PCTL_PULSE_BIT] <= 1'b0;
        end else if (progCtlWr) begin
            byte_memory_program_control <= progCtlWrData;
        end
    end

    // tick counter; manual mode holds the pulse until software clears
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            byteTicks_r <= '0;
            bytePulse   <= 1'b0;
            cycleDone   <= 1'b0;
        end else begin
            bytePulse <= pulseOn && !stopped;
            cycleDone <= doneNow;
            if (!pulseOn)
                byteTicks_r <= '0;
            else if (divTick && byteTicks_r != '1)
                byteTicks_r <= byteTicks_r + 1'b1;
        end
    end

    // selective bit writes: program events counted until an erase
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            selectiveWrites <= '0;
        end else if (doneNow && eraseSel) begin
            selectiveWrites <= '0;
        end else if (doneNow && selectiveWrites < 4'(SEL_WRITES_MAX)) begin
            selectiveWrites <= selectiveWrites + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // flash row buffer and fixed-time sequencer
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rowBuf_r <= '0;
        end else if (flashRowWr && flState_r == FL_IDLE) begin
            rowBuf_r[flashRowIdx*DATA_W +: DATA_W] <= flashRowData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flState_r       <= FL_IDLE;
            flCnt_r         <= '0;
            flashBusy       <= 1'b0;
            flashProgPulse  <= 1'b0;
            flashErasePulse <= 1'b0;
            flashRowOut     <= '0;
        end else begin
            case (flState_r)
                FL_IDLE: begin
                    flCnt_r <= '0;
                    if (flashEraseStart) begin
                        flState_r       <= FL_ERASE;
                        flashBusy       <= 1'b1;
                        flashErasePulse <= 1'b1;
                    end else if (flashProgStart) begin
                        flState_r      <= FL_PROG;
                        flashBusy      <= 1'b1;
                        flashProgPulse <= 1'b1;
                        flashRowOut    <= rowBuf_r;
                    end
                end
                FL_PROG: begin
                    flCnt_r <= flCnt_r + 1'b1;
                    if (flCnt_r == TICK_W'(FLASH_PROG_CYCLES - 1)) begin
                        flState_r      <= FL_IDLE;
                        flashBusy      <= 1'b0;
                        flashProgPulse <= 1'b0;
                    end
                end
                FL_ERASE: begin
                    flCnt_r <= flCnt_r + 1'b1;
                    if (flCnt_r == TICK_W'(FLASH_ERASE_CYCLES - 1)) begin
                        flState_r       <= FL_IDLE;
                        flashBusy       <= 1'b0;
                        flashErasePulse <= 1'b0;
                    end
                end
                default: begin
                    flState_r <= FL_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // stop state
    // --------------------------------------------------------------
    // wake is taken on any mclk edge, no interrupt-clock alignment
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stopped <= 1'b0;
        end else if (wakeReq) begin
            stopped <= 1'b0;
        end else if (stopReq) begin
            stopped <= 1'b1;
        end
    end
endmodule // nvm_program_erase_control

// ### verification/nvm_pec_chk.sv
// concurrent checks on the program/erase control block ports
// assumes a bind onto the block top, one mclk domain, sync reset
`timescale 1ns/1ns
module nvm_pec_chk
    import nvm_ctl_pkg::*;
#(
    parameter int FLASH_PROG_CYCLES  = FLASH_PROG_CYC,
    parameter int FLASH_ERASE_CYCLES = FLASH_ERASE_CYC
) (
    input wire logic                        mclk,
    input wire logic                        sys_rst,
    input wire logic [PRESCALE_W-1:0]       shadowDivider,
    input wire logic                        dividerWrLow,
    input wire logic [DATA_W-1:0]           dividerWrData,
    input wire logic                        flashProgStart,
    input wire logic                        flashEraseStart,
    input wire logic                        stopReq,
    input wire logic                        wakeReq,
    input wire logic [DIVH_W-1:0]           timebase_divider_high,
    input wire logic [DIVL_W-1:0]           timebase_divider_low,
    input wire logic [PCTL_W-1:0]           byte_memory_program_control,
    input wire logic                        flashBusy,
    input wire logic                        flashProgPulse,
    input wire logic                        flashErasePulse,
    input wire logic [ROW_BYTES*DATA_W-1:0] flashRowOut,
    input wire logic                        bytePulse,
    input wire logic [3:0]                  selectiveWrites,
    input wire logic                        cycleDone,
    input wire logic                        stopped
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [15:0] busyCnt_r;
    // busy length counter, cleared whenever idle
    always_ff @(posedge mclk) begin
        if (sys_rst || !flashBusy) busyCnt_r <= 16'h0000;
        else busyCnt_r <= busyCnt_r + 16'h0001;
    end
    a_prog_start:
    assert property (!flashBusy && flashProgStart && !flashEraseStart
        |=> flashBusy && flashProgPulse) else $error("no row program");
    a_erase_wins:
    assert property (!flashBusy && flashEraseStart
        |=> flashErasePulse && !flashProgPulse) else $error("no erase");
    a_busy_len:
    assert property ($fell(flashBusy) |-> busyCnt_r == ($past(
        flashErasePulse) ? FLASH_ERASE_CYCLES : FLASH_PROG_CYCLES))
        else $error("flash time wrong");
    a_row_hold:
    assert property ($past(flashBusy) |-> $stable(flashRowOut))
        else $error("row changed while busy");
    a_div_reload:
    assert property (disable iff (1'b0) sys_rst |=> {timebase_divider_high,
        timebase_divider_low} == shadowDivider) else $error("no reload");
    a_div_low_wr:
    assert property (dividerWrLow |=> timebase_divider_low ==
        $past(dividerWrData)) else $error("low divider write lost");
    a_auto_clear:
    assert property (cycleDone && byte_memory_program_control[PCTL_AUTO_BIT]
        |-> !byte_memory_program_control[PCTL_PULSE_BIT])
        else $error("no auto clear");
    a_done_pulse:
    assert property (cycleDone |=> !cycleDone) else $error("done too long");
    a_pulse_follow:
    assert property (!$past(sys_rst) |-> bytePulse == $past(
        byte_memory_program_control[0] && !stopped)) else $error("pulse");
    a_sel_limit:
    assert property (selectiveWrites <= 4'h8) else $error("count over 8");
    a_stop_wake:
    assert property (stopReq || wakeReq |=> stopped == !$past(wakeReq))
        else $error("stop state wrong");
    a_stop_freeze:
    assert property (stopped && $past(stopped) && $past(stopped, 2)
        |-> !cycleDone) else $error("op ran while stopped");
endmodule // nvm_pec_chk

// ### verification/test_nvm_program_erase_control.sv
// self-checking bench for the program/erase control block
// assumes checker file compiled first; oscillator made here at 50 MHz
`timescale 1ns/1ns
module test_nvm_program_erase_control import nvm_ctl_pkg::*;;
    // ----------------------------------------
    // signals, tables and tasks
    // ----------------------------------------
    localparam int FP = 20;
    localparam int FE = 50;
    typedef struct packed {logic hi; logic [7:0] d; logic [9:0] e;} div_s;
    typedef struct packed {logic [7:0] c; int t; logic [7:0] e;
        logic [3:0] s;} op_s;
    div_s divRows[3] = '{'{1'h1, 8'h03, 10'h3A5}, '{1'h0, 8'h01, 10'h301},
        '{1'h1, 8'hFC, 10'h001}};
    op_s opRows[4] = '{'{8'h01, 10, 8'h01, 4'h1}, '{8'h21, 6, 8'h20, 4'h2},
        '{8'h05, 10, 8'h05, 4'h0}, '{8'h25, 6, 8'h24, 4'h0}};
    logic mclk = 0, sys_rst = 1, external_oscillator_clock = 0;
    logic dividerWrHigh = 0, dividerWrLow = 0, progCtlWr = 0;
    logic byteLatchWr = 0, flashRowWr = 0, flashProgStart = 0;
    logic flashEraseStart = 0, stopReq = 0, wakeReq = 0;
    logic [PRESCALE_W-1:0] shadowDivider = 10'h2A5;
    logic [DATA_W-1:0] dividerWrData = '0, progCtlWrData = '0;
    logic [DATA_W-1:0] byteLatchData = '0, flashRowData = '0;
    logic [ROW_IDX_W-1:0] flashRowIdx = '0;
    logic [DIVH_W-1:0] timebase_divider_high;
    logic [DIVL_W-1:0] timebase_divider_low;
    logic [PCTL_W-1:0] byte_memory_program_control;
    logic flashBusy, flashProgPulse, flashErasePulse, bytePulse;
    logic cycleDone, stopped;
    logic [ROW_BYTES*DATA_W-1:0] flashRowOut;
    logic [3:0] selectiveWrites;
    logic [PRESCALE_W-1:0] divNow;
    assign divNow = {timebase_divider_high, timebase_divider_low};
    int mismatches = 0, samples_checked = 0, cyc = 0, n;
    nvm_program_erase_control #(.FLASH_PROG_CYCLES(FP),
        .FLASH_ERASE_CYCLES(FE)) dut_u (.*);
    // clock, and an oscillator rising every second mclk edge
    always #5 mclk = ~mclk;
    always @(posedge mclk)
        #1 external_oscillator_clock <= ~external_oscillator_clock;
    task automatic tick(); @(posedge mclk); #1; endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // clear then set program control, so each op starts fresh
    task automatic ctlWr(input logic [7:0] c);
        progCtlWr = 1; progCtlWrData = 8'h00; tick();
        progCtlWrData = c; tick(); progCtlWr = 0;
    endtask
    task automatic waitDone(); n = 0;
        while (cycleDone !== 1'b1 && n < 400) begin tick(); n++; end
    endtask
    task automatic flashWait(); n = 0;
        while (flashBusy === 1'b1 && n < 200) begin tick(); n++; end
    endtask
    // hang guard: whole run is under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin mismatches++; wrap_up(); end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) tick();
        sys_rst = 0;
        chk({timebase_divider_high, timebase_divider_low}, 10'h2A5);
        // strobes held between rows so none is set twice in one step
        foreach (divRows[i]) begin
            dividerWrHigh = divRows[i].hi;
            dividerWrLow = !divRows[i].hi;
            dividerWrData = divRows[i].d;
            tick();
            chk(divNow, divRows[i].e);
        end
        dividerWrHigh = 0;
        dividerWrLow = 0;
        // tick every 4 mclk: allow two ticks of phase slack early, one tick late
        foreach (opRows[i]) begin
            ctlWr(opRows[i].c); waitDone(); tick();
            n -= 4 * opRows[i].t;
            chk(n >= -8 && n <= 4, 1);
            chk(byte_memory_program_control, opRows[i].e);
            chk(selectiveWrites, opRows[i].s);
        end
        // manual op: pulse bit stays set, yet completion reported once
        ctlWr(8'h01);
        waitDone();
        chk(n <= 44, 1);
        n = 0;
        repeat (60) begin
            tick();
            n += cycleDone;
        end
        chk({selectiveWrites, n[3:0]}, 8'h10);
        repeat (9) begin ctlWr(8'h21); waitDone(); tick(); end
        chk(selectiveWrites, 4'h8);
        stopReq = 1; tick(); stopReq = 0;
        ctlWr(8'h21); n = 0;
        repeat (60) begin tick(); n += (cycleDone | bytePulse); end
        chk({stopped, n[7:0]}, 9'h100);
        wakeReq = 1; tick(); wakeReq = 0; waitDone();
        chk(n <= 28, 1);
        for (int i = 0; i < ROW_BYTES; i++) begin
            flashRowWr = 1; flashRowIdx = i[5:0];
            flashRowData = 8'hA0 ^ i[7:0]; tick();
        end
        flashRowWr = 0; flashProgStart = 1; tick();
        chk({flashBusy, flashProgPulse, flashErasePulse}, 3'h6);
        chk({flashRowOut[8*63+:8], flashRowOut[7:0]}, 16'h9FA0);
        flashRowWr = 1; flashRowIdx = '0; flashRowData = 8'h00; tick();
        flashRowWr = 0; flashProgStart = 0; flashWait();
        chk(n, FP - 1);
        chk(flashRowOut[7:0], 8'hA0);
        flashProgStart = 1; flashEraseStart = 1; tick();
        flashProgStart = 0; flashEraseStart = 0;
        chk({flashBusy, flashProgPulse, flashErasePulse}, 3'h5);
        flashWait();
        chk(n, FE);
        // a fresh snapshot shows whether the refused write reached the row
        flashProgStart = 1;
        tick();
        flashProgStart = 0;
        chk(flashRowOut[7:0], 8'hA0);
        flashWait();
        shadowDivider = 10'h155; sys_rst = 1; tick(); sys_rst = 0;
        chk({timebase_divider_high, timebase_divider_low}, 10'h155);
        chk({byte_memory_program_control, selectiveWrites}, 12'h000);
        wrap_up();
    end
endmodule // test_nvm_program_erase_control
bind nvm_program_erase_control nvm_pec_chk #(
    .FLASH_PROG_CYCLES(FLASH_PROG_CYCLES),
    .FLASH_ERASE_CYCLES(FLASH_ERASE_CYCLES)) chk_u (.*);
